//--- rtl/fpm_pkg.sv
// Shared constants and types for the fetch pipeline and data memory map block.
package fpm_pkg;

  // Widths of the program and data paths.
  localparam int PC_W    = 13;
  localparam int WORD_W  = 14;
  localparam int DATA_W  = 8;
  localparam int LOCAL_W = 7;
  localparam int BANK_W  = 2;
  localparam int EA_W    = 9;

  // Program memory vectors.
  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

  // Local offsets of the core registers, mirrored in every bank.
  localparam logic [LOCAL_W-1:0] OFF_INDIRECT  = 7'h00;
  localparam logic [LOCAL_W-1:0] OFF_PC_LOW    = 7'h02;
  localparam logic [LOCAL_W-1:0] OFF_STATUS    = 7'h03;
  localparam logic [LOCAL_W-1:0] OFF_POINTER   = 7'h04;
  localparam logic [LOCAL_W-1:0] OFF_PC_HIGH   = 7'h0A;
  localparam logic [LOCAL_W-1:0] OFF_INT_CTRL  = 7'h0B;

  // First general-purpose location of a bank; below it lie the special registers.
  localparam logic [LOCAL_W-1:0] GPR_BASE = 7'h20;

  // Field positions inside the status register.
  localparam int IND_BANK_BIT = 7;
  localparam int BANK_HI_BIT  = 6;
  localparam int BANK_LO_BIT  = 5;

  // Bits of the high latch that reach the program counter.
  localparam int PC_HIGH_USED_W = 5;

  // Reset values of the core registers.
  localparam logic [DATA_W-1:0] STATUS_RST   = 8'h00;
  localparam logic [DATA_W-1:0] POINTER_RST  = 8'h00;
  localparam logic [DATA_W-1:0] PC_HIGH_RST  = 8'h00;
  localparam logic [DATA_W-1:0] INT_CTRL_RST = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RST     = 14'h0000;

  // The four phases of one instruction cycle.
  typedef enum logic [1:0] {
    FPM_PH_ONE,
    FPM_PH_TWO,
    FPM_PH_THREE,
    FPM_PH_FOUR
  } fpm_phase_t;

endpackage

//--- rtl/fpm_ram_if.sv
// Interface between the core sequencer and its general-purpose static RAM.
`timescale 1ns/1ps
interface fpm_ram_if #(
  parameter int AW = 9,
  parameter int DW = 8
);
  logic          rd_en;    // Read strobe; data follows one clock later.
  logic          wr_en;    // Write strobe.
  logic [AW-1:0] addr;     // Banked word address.
  logic [DW-1:0] wr_data;  // Data to be written.
  logic [DW-1:0] rd_data;  // Registered read data.

  // The sequencer drives the strobes and takes the read data.
  modport ctrl (output rd_en, output wr_en, output addr, output wr_data, input rd_data);
  // The memory answers.
  modport mem (input rd_en, input wr_en, input addr, input wr_data, output rd_data);
endinterface

//--- rtl/fpm_gpr_ram.sv
// General-purpose static RAM with a registered read port.
`timescale 1ns/1ps
module fpm_gpr_ram #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  fpm_ram_if.mem    bus
);
  import fpm_pkg::*;

  // Storage array; contents are undefined after power-up, as for real RAM.
  logic [DW-1:0] mem_r [0:(2**AW)-1];
  // Read data register.
  logic [DW-1:0] rd_data_r;

  // Array write; no reset so it maps onto plain RAM cells.
  always_ff @(posedge core_clk)
  begin
    if (bus.wr_en)
    begin
      mem_r[bus.addr] <= bus.wr_data;
    end
  end

  // Read register, cleared by reset so the port shows zero until its first read.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_r <= '0;
    end
    else if (bus.rd_en)
    begin
      rd_data_r <= mem_r[bus.addr];
    end
  end

  assign bus.rd_data = rd_data_r;
endmodule

//--- rtl/fpm_core.sv
// Phase generator, fetch/execute pipeline and banked data memory decoder.
`timescale 1ns/1ps
// Function
// - Clock divided by four into phases
// - Program counter increments in phase one
// - Program word latched in phase four
// - Instruction register loads in phase one
// - Operand read phase two, write phase four
// - Fetch overlaps execute, one per cycle
// - Program counter change flushes fetched word
// - Program counter is thirteen bits wide
// - Small variants wrap fetch address
// - Reset starts fetch at address zero
// - Interrupt redirects fetch to address four
// - Status bits six, five select bank
// - Each bank spans 128 locations
// - Low addresses special, upper addresses RAM
// - Core registers mirrored across banks
// - Direct and pointer-based indirect access
// - Location zero redirects through pointer
// - Unimplemented locations read as zero
module fpm_core #(
  parameter int PROG_AW   = 13,  // Implemented program address bits: 11, 12 or 13.
  parameter int GPR_BANKS = 2    // Banks that hold general-purpose RAM.
) (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  output logic [fpm_pkg::PC_W-1:0]         prog_addr,
  input  wire logic [fpm_pkg::WORD_W-1:0]  prog_data,
  output logic                             phase_one,
  output logic                             phase_two,
  output logic                             phase_three,
  output logic                             phase_four,
  output logic [fpm_pkg::WORD_W-1:0]       instr_word,
  output logic                             instr_valid,
  input  wire logic [fpm_pkg::LOCAL_W-1:0] exec_file_addr,
  input  wire logic                        exec_wr_en,
  input  wire logic [fpm_pkg::DATA_W-1:0]  exec_wr_data,
  input  wire logic                        branch_req,
  input  wire logic [fpm_pkg::PC_W-1:0]    branch_target,
  input  wire logic                        irq_req,
  output logic                             irq_ack,
  output logic [fpm_pkg::DATA_W-1:0]       operand,
  output logic                             bank_select_high,
  output logic                             bank_select_low,
  output logic [fpm_pkg::DATA_W-1:0]       interrupt_control_reg
);
  import fpm_pkg::*;

  // Address mask that drops counter bits above the implemented program memory.
  localparam logic [PC_W-1:0]   PROG_MASK   = PC_W'((1 << PROG_AW) - 1);
  // Number of RAM banks at the width of the bank comparison.
  localparam logic [BANK_W:0]   GPR_BANKS_L = (BANK_W + 1)'(GPR_BANKS);

  // Phase sequencer state and its registered one-hot copies.
  fpm_phase_t       phase_r;
  fpm_phase_t       phase_nxt;
  logic             phase_one_r;
  logic             phase_two_r;
  logic             phase_three_r;
  logic             phase_four_r;

  // Fetch side of the pipeline.
  logic [PC_W-1:0]   pc_r;          // Program counter.
  logic [PC_W-1:0]   pc_nxt;        // Its next value.
  logic [PC_W-1:0]   prog_addr_r;   // Wrapped address presented to program memory.
  logic [WORD_W-1:0] fetch_word_r;  // Word latched at the end of the fetch cycle.
  logic              fetch_valid_r; // Low when the fetched word was flushed.
  logic              fetch_run_r;   // High once a real fetch cycle has begun.

  // Execute side of the pipeline.
  logic [WORD_W-1:0] ir_r;          // Instruction register.
  logic              ir_valid_r;    // High when the instruction register holds real work.
  logic              irq_ack_r;     // One-cycle acknowledge of a taken interrupt.

  // Core registers, reached from every bank.
  logic [DATA_W-1:0] status_r;
  logic [DATA_W-1:0] pointer_r;
  logic [DATA_W-1:0] pc_high_r;
  logic [DATA_W-1:0] int_ctrl_r;

  // Operand path.
  logic              sel_gpr_r;     // Operand comes from RAM.
  logic [DATA_W-1:0] core_val_r;    // Operand captured from the core registers.
  logic [DATA_W-1:0] operand_r;     // Operand handed to the execute logic.

  // Decoded phases of the present clock cycle.
  wire in_ph1 = (phase_r == FPM_PH_ONE);
  wire in_ph2 = (phase_r == FPM_PH_TWO);
  wire in_ph3 = (phase_r == FPM_PH_THREE);
  wire in_ph4 = (phase_r == FPM_PH_FOUR);

  // Address location zero selects the pointer instead of a physical register.
  wire              is_indirect = (exec_file_addr == OFF_INDIRECT);
  // Effective nine-bit address: bank bits plus local offset.
  wire [EA_W-1:0]   eff_addr    = is_indirect ?
                                  {status_r[IND_BANK_BIT], pointer_r} :
                                  {status_r[BANK_HI_BIT], status_r[BANK_LO_BIT],
                                   exec_file_addr};
  // Local offset inside the bank and the bank number; each bank spans 128 places.
  wire [LOCAL_W-1:0] loc        = eff_addr[LOCAL_W-1:0];
  wire [BANK_W-1:0]  bank       = eff_addr[EA_W-1:LOCAL_W];

  // Core register hits ignore the bank, which mirrors them everywhere.
  wire hit_pc_low   = (loc == OFF_PC_LOW);
  wire hit_status   = (loc == OFF_STATUS);
  wire hit_pointer  = (loc == OFF_POINTER);
  wire hit_pc_high  = (loc == OFF_PC_HIGH);
  wire hit_int_ctrl = (loc == OFF_INT_CTRL);
  wire core_hit     = hit_pc_low | hit_status | hit_pointer | hit_pc_high | hit_int_ctrl;

  // Locations above the special region of a RAM-equipped bank go to RAM.
  wire gpr_hit = (loc >= GPR_BASE) && ({1'b0, bank} < GPR_BANKS_L);

  // Core register read value; anything unimplemented, including the window
  // reached through itself, reads as zero.
  wire [DATA_W-1:0] core_rd_val = hit_pc_low   ? pc_r[DATA_W-1:0] :
                                  hit_status   ? status_r :
                                  hit_pointer  ? pointer_r :
                                  hit_pc_high  ? pc_high_r :
                                  hit_int_ctrl ? int_ctrl_r :
                                  '0;

  // A flushed slot writes nothing, so the discarded word has no side effect.
  wire wr_ok    = in_ph4 && exec_wr_en && ir_valid_r;
  wire pcl_wr   = wr_ok && hit_pc_low;
  // Interrupt wins over a branch and over a computed jump in the same cycle.
  wire take_irq = in_ph4 && irq_req;
  wire take_br  = in_ph4 && ir_valid_r && branch_req;
  wire redirect = take_irq || take_br || pcl_wr;

  // Computed jump target: high latch bits joined with the written low byte.
  wire [PC_W-1:0] pcl_target = {pc_high_r[PC_HIGH_USED_W-1:0], exec_wr_data};

  // RAM port wiring; the read issues in phase two, the write lands in phase four.
  fpm_ram_if #(.AW(EA_W), .DW(DATA_W)) ram_bus ();
  assign ram_bus.rd_en   = in_ph2 && gpr_hit;
  assign ram_bus.wr_en   = wr_ok && gpr_hit;
  assign ram_bus.addr    = eff_addr;
  assign ram_bus.wr_data = exec_wr_data;

  // Backing store for the general-purpose locations.
  fpm_gpr_ram #(.AW(EA_W), .DW(DATA_W)) i_fpm_gpr_ram (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .bus      (ram_bus)
  );

  // Phase rotation; reset parks in phase four so the first cycle is phase one.
  always_comb
  begin
    case (phase_r)
      FPM_PH_ONE:   phase_nxt = FPM_PH_TWO;
      FPM_PH_TWO:   phase_nxt = FPM_PH_THREE;
      FPM_PH_THREE: phase_nxt = FPM_PH_FOUR;
      FPM_PH_FOUR:  phase_nxt = FPM_PH_ONE;
      default:      phase_nxt = FPM_PH_ONE;
    endcase
  end

  // Next program counter. Increment in phase one, redirect in phase four.
  always_comb
  begin
    pc_nxt = pc_r;
    if (in_ph1)
    begin
      pc_nxt = pc_r + 13'h0001;
    end
    else if (take_irq)
    begin
      pc_nxt = IRQ_VECTOR;
    end
    else if (take_br)
    begin
      pc_nxt = branch_target;
    end
    else if (pcl_wr)
    begin
      pc_nxt = pcl_target;
    end
  end

  // Phase state and its one-hot outputs, registered together so they never skew.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_r       <= FPM_PH_FOUR;
      phase_one_r   <= 1'b0;
      phase_two_r   <= 1'b0;
      phase_three_r <= 1'b0;
      phase_four_r  <= 1'b1;
    end
    else
    begin
      phase_r       <= phase_nxt;
      phase_one_r   <= (phase_nxt == FPM_PH_ONE);
      phase_two_r   <= (phase_nxt == FPM_PH_TWO);
      phase_three_r <= (phase_nxt == FPM_PH_THREE);
      phase_four_r  <= (phase_nxt == FPM_PH_FOUR);
    end
  end

  // Fetch: present the wrapped address in phase one, latch the word in phase four.
  // Masking keeps the counter itself at full width, so a wrapped fetch still
  // reports the unwrapped counter value through the low byte register.
  // Reset parks in phase four, so the first edge would latch a word that was
  // never addressed; it stays invalid until a real fetch cycle has run.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_r          <= RESET_VECTOR;
      prog_addr_r   <= RESET_VECTOR;
      fetch_word_r  <= WORD_RST;
      fetch_valid_r <= 1'b0;
      fetch_run_r   <= 1'b0;
    end
    else
    begin
      pc_r <= pc_nxt;
      if (in_ph1)
      begin
        prog_addr_r <= pc_r & PROG_MASK;
        fetch_run_r <= 1'b1;
      end
      if (in_ph4)
      begin
        fetch_word_r  <= prog_data;
        fetch_valid_r <= fetch_run_r && !redirect;
      end
    end
  end

  // Execute: the fetched word moves into the instruction register in phase one
  // while the next fetch starts, which gives one instruction per cycle.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ir_r       <= WORD_RST;
      ir_valid_r <= 1'b0;
      irq_ack_r  <= 1'b0;
    end
    else
    begin
      if (in_ph1)
      begin
        ir_r       <= fetch_word_r;
        ir_valid_r <= fetch_valid_r;
      end
      irq_ack_r <= take_irq;
    end
  end

  // Core register writes in phase four; every bank reaches the same flops.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_r   <= STATUS_RST;
      pointer_r  <= POINTER_RST;
      pc_high_r  <= PC_HIGH_RST;
      int_ctrl_r <= INT_CTRL_RST;
    end
    else if (wr_ok)
    begin
      if (hit_status)
      begin
        status_r <= exec_wr_data;
      end
      if (hit_pointer)
      begin
        pointer_r <= exec_wr_data;
      end
      if (hit_pc_high)
      begin
        pc_high_r <= exec_wr_data;
      end
      if (hit_int_ctrl)
      begin
        int_ctrl_r <= exec_wr_data;
      end
    end
  end

  // Operand: select in phase two, merge with the RAM read data in phase three.
  // The RAM answers one clock late, hence the extra stage.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_gpr_r  <= 1'b0;
      core_val_r <= '0;
      operand_r  <= '0;
    end
    else
    begin
      if (in_ph2)
      begin
        sel_gpr_r  <= gpr_hit;
        core_val_r <= core_rd_val;
      end
      if (in_ph3)
      begin
        operand_r <= sel_gpr_r ? ram_bus.rd_data : core_val_r;
      end
    end
  end

  // Ports straight from their flip-flops.
  assign prog_addr             = prog_addr_r;
  assign phase_one             = phase_one_r;
  assign phase_two             = phase_two_r;
  assign phase_three           = phase_three_r;
  assign phase_four            = phase_four_r;
  assign instr_word            = ir_r;
  assign instr_valid           = ir_valid_r;
  assign irq_ack               = irq_ack_r;
  assign operand               = operand_r;
  assign bank_select_high      = status_r[BANK_HI_BIT];
  assign bank_select_low       = status_r[BANK_LO_BIT];
  assign interrupt_control_reg = int_ctrl_r;

  // Checks on the sequencing and the memory decode.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  phase_order_a: assert property (phase_one_r |=> phase_two_r ##1 phase_three_r
                                  ##1 phase_four_r ##1 phase_one_r)
    else $error("Phases out of order.");
  phase_onehot_a: assert property ($onehot({phase_one_r, phase_two_r,
                                            phase_three_r, phase_four_r}))
    else $error("Phase outputs not one-hot.");
  pc_step_a: assert property (phase_one_r |=> pc_r == PC_W'($past(pc_r) + 13'h0001))
    else $error("Program counter did not step in phase one.");
  word_latch_a: assert property (phase_four_r |=> fetch_word_r == $past(prog_data))
    else $error("Program word not latched in phase four.");
  ir_hold_a: assert property (!phase_one_r |=> ir_r == $past(ir_r))
    else $error("Instruction register moved outside phase one.");
  addr_wrap_a: assert property (phase_one_r |=> prog_addr == ($past(pc_r) & PROG_MASK))
    else $error("Program address not wrapped.");
  irq_vector_a: assert property (phase_four_r && irq_req |=> pc_r == IRQ_VECTOR
                                 ##1 prog_addr == (IRQ_VECTOR & PROG_MASK))
    else $error("Interrupt did not fetch from its vector.");
  flush_slot_a: assert property (phase_four_r && redirect |=> ##1 (!instr_valid)[*4])
    else $error("Flushed word reached execution.");
  ram_phase_a: assert property (ram_bus.wr_en |-> phase_four_r && !ram_bus.rd_en)
    else $error("RAM written outside phase four.");
  read_phase_a: assert property (ram_bus.rd_en |-> phase_two_r)
    else $error("RAM read outside phase two.");
  unimpl_zero_a: assert property (phase_two_r && !gpr_hit && !core_hit
                                  |=> ##1 operand == 8'h00)
    else $error("Unimplemented location did not read zero.");

  branch_flush_c: cover property (take_br ##8 instr_valid);
  irq_taken_c: cover property (take_irq ##1 irq_ack);
  indirect_ram_c: cover property (is_indirect && gpr_hit && ram_bus.wr_en);
  computed_jump_c: cover property (pcl_wr);
endmodule

//--- tb/test_fetch_pipeline_memory_map.sv
// Self-checking testbench for the fetch pipeline and banked data memory block.
`timescale 1ns/1ps
`define check_eq(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("mismatch at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_fetch_pipeline_memory_map;
  import fpm_pkg::*;

  localparam int WRAP_AW = 11;  // Second core models the 2K-word variant.

  logic                 core_clk;        // Oscillator input, 40 ns period.
  logic                 arst_n;          // Asynchronous reset, active low.
  logic [PC_W-1:0]      prog_addr;       // Full-size core fetch address.
  logic [PC_W-1:0]      prog_addr_w;     // Small core fetch address.
  logic [WORD_W-1:0]    prog_data;       // Program word returned to the full core.
  logic [WORD_W-1:0]    prog_data_w;     // Program word returned to the small core.
  logic                 phase_one;       // Phase levels of the full core.
  logic                 phase_two;
  logic                 phase_three;
  logic                 phase_four;
  logic [3:0]           phases;          // Phase levels gathered for one compare.
  logic [WORD_W-1:0]    instr_word;      // Instruction register.
  logic                 instr_valid;     // Instruction register holds a real word.
  logic [LOCAL_W-1:0]   exec_file_addr;  // Direct file address of the instruction.
  logic                 exec_wr_en;      // Write request.
  logic [DATA_W-1:0]    exec_wr_data;    // Write data.
  logic                 branch_req;      // Program counter change request.
  logic [PC_W-1:0]      branch_target;   // Branch destination.
  logic                 irq_req;         // Interrupt request.
  logic                 irq_ack;         // Interrupt taken pulse.
  logic [DATA_W-1:0]    operand;         // Source operand read back.
  logic                 bank_select_high;
  logic                 bank_select_low;
  logic [DATA_W-1:0]    interrupt_control_reg;
  int                   err_count;       // Mismatches seen.
  int                   compares;        // Comparisons made.

  // The program store is a fixed pattern of the address, so every word is distinct.
  function automatic logic [WORD_W-1:0] word_of(input logic [PC_W-1:0] a);
    return {1'b1, a} ^ 14'h1555;
  endfunction

  assign prog_data   = word_of(prog_addr);
  assign prog_data_w = word_of(prog_addr_w);
  assign phases      = {phase_one, phase_two, phase_three, phase_four};

  fpm_core #(.PROG_AW(PC_W), .GPR_BANKS(2)) i_fpm_core (
    .core_clk(core_clk), .arst_n(arst_n), .prog_addr(prog_addr), .prog_data(prog_data),
    .phase_one(phase_one), .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .instr_word(instr_word), .instr_valid(instr_valid),
    .exec_file_addr(exec_file_addr), .exec_wr_en(exec_wr_en), .exec_wr_data(exec_wr_data),
    .branch_req(branch_req), .branch_target(branch_target), .irq_req(irq_req),
    .irq_ack(irq_ack), .operand(operand), .bank_select_high(bank_select_high),
    .bank_select_low(bank_select_low), .interrupt_control_reg(interrupt_control_reg));

  // Only the fetch address of the small core is watched; it shares every input but its program data.
  fpm_core #(.PROG_AW(WRAP_AW), .GPR_BANKS(2)) i_fpm_core_wrap (
    .core_clk(core_clk), .arst_n(arst_n), .prog_addr(prog_addr_w), .prog_data(prog_data_w),
    .phase_one(), .phase_two(), .phase_three(), .phase_four(), .instr_word(),
    .instr_valid(), .exec_file_addr(exec_file_addr), .exec_wr_en(exec_wr_en),
    .exec_wr_data(exec_wr_data), .branch_req(branch_req), .branch_target(branch_target),
    .irq_req(irq_req), .irq_ack(), .operand(), .bank_select_high(),
    .bank_select_low(), .interrupt_control_reg());

  // Free-running clock.
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  // Advance n edges and land just after the last one, where outputs are settled.
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // Align to a phase one cycle; bounded so a dead phase counter cannot hang us.
  task automatic to_phase_one();
    int guard;
    guard = 0;
    while (phase_one !== 1'b1 && guard < 8)
    begin
      step(1);
      guard++;
    end
  endtask

  // One instruction cycle of data memory traffic, ending in the next phase one.
  task automatic op(input logic [LOCAL_W-1:0] a, input logic we, input logic [DATA_W-1:0] wd,
                    input logic chk, input logic [DATA_W-1:0] exp);
    to_phase_one();
    exec_file_addr = a;
    exec_wr_en     = we;
    exec_wr_data   = wd;
    step(3);
    if (chk)
      `check_eq(operand, exp)
    step(1);
  endtask

  // Raise a branch or interrupt for exactly one phase four edge.
  task automatic jump(input logic br, input logic irq, input logic [PC_W-1:0] tgt);
    to_phase_one();
    branch_req    = br;
    irq_req       = irq;
    branch_target = tgt;
    op(7'h00, 1'b0, 8'h00, 1'b0, 8'h00);
    branch_req    = 1'b0;
    irq_req       = 1'b0;
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles, this allows 5000.
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    err_count = 0;
    compares = 0;
    arst_n = 1'b0;
    exec_file_addr = 7'h00;
    exec_wr_en = 1'b0;
    exec_wr_data = 8'h00;
    branch_req = 1'b0;
    branch_target = 13'h0000;
    irq_req = 1'b0;
    step(20);
    `check_eq(prog_addr, RESET_VECTOR)
    `check_eq(interrupt_control_reg, INT_CTRL_RST)
    `check_eq({bank_select_high, bank_select_low}, 2'h0)
    arst_n = 1'b1;
    // Four one-hot phases rotate, starting with phase one after release.
    for (int k = 0; k < 8; k++)
    begin
      step(1);
      `check_eq(phases, 4'h8 >> (k % 4))
      `check_eq(instr_valid, k >= 5)
    end
    // Sequential fetch: the word fetched in one cycle executes in the next.
    for (int k = 2; k < 5; k++)
    begin
      to_phase_one();
      step(1);
      `check_eq(prog_addr, 13'(k))
      `check_eq(instr_word, word_of(13'(k - 1)))
      `check_eq(instr_valid, 1'b1)
    end
    // Bank selection, mirroring and the RAM region boundaries.
    op(OFF_STATUS, 1'b1, 8'h20, 1'b0, 8'h00);
    `check_eq({bank_select_high, bank_select_low}, 2'h1)
    op(7'h20, 1'b1, 8'h5A, 1'b0, 8'h00);
    op(OFF_INT_CTRL, 1'b1, 8'hC3, 1'b0, 8'h00);
    `check_eq(interrupt_control_reg, 8'hC3)
    op(OFF_STATUS, 1'b1, 8'h00, 1'b0, 8'h00);
    op(OFF_INT_CTRL, 1'b0, 8'h00, 1'b1, 8'hC3);
    op(7'h20, 1'b1, 8'h11, 1'b0, 8'h00);
    op(7'h7F, 1'b1, 8'h77, 1'b0, 8'h00);
    op(7'h20, 1'b0, 8'h00, 1'b1, 8'h11);
    op(7'h7F, 1'b0, 8'h00, 1'b1, 8'h77);
    op(OFF_STATUS, 1'b1, 8'h20, 1'b0, 8'h00);
    op(7'h20, 1'b0, 8'h00, 1'b1, 8'h5A);
    // Bank 2 holds no RAM: writes vanish and reads give zero.
    op(OFF_STATUS, 1'b1, 8'h40, 1'b0, 8'h00);
    `check_eq({bank_select_high, bank_select_low}, 2'h2)
    op(OFF_STATUS, 1'b0, 8'h00, 1'b1, 8'h40);
    op(7'h20, 1'b1, 8'hEE, 1'b0, 8'h00);
    op(7'h20, 1'b0, 8'h00, 1'b1, 8'h00);
    op(7'h05, 1'b0, 8'h00, 1'b1, 8'h00);
    // Indirect access through the pointer, including a pointer to location zero.
    op(OFF_STATUS, 1'b1, 8'h00, 1'b0, 8'h00);
    op(OFF_POINTER, 1'b1, 8'h21, 1'b0, 8'h00);
    op(OFF_INDIRECT, 1'b1, 8'h99, 1'b0, 8'h00);
    op(7'h21, 1'b0, 8'h00, 1'b1, 8'h99);
    op(OFF_POINTER, 1'b1, 8'hA0, 1'b0, 8'h00);
    op(OFF_INDIRECT, 1'b0, 8'h00, 1'b1, 8'h5A);
    op(OFF_POINTER, 1'b1, 8'h00, 1'b0, 8'h00);
    op(OFF_INDIRECT, 1'b0, 8'h00, 1'b1, 8'h00);
    // Status bit seven moves the indirect access into bank 2, which has no RAM.
    op(OFF_POINTER, 1'b1, 8'h20, 1'b0, 8'h00);
    op(OFF_STATUS, 1'b1, 8'h80, 1'b0, 8'h00);
    op(OFF_INDIRECT, 1'b0, 8'h00, 1'b1, 8'h00);
    op(OFF_STATUS, 1'b1, 8'h00, 1'b0, 8'h00);
    op(OFF_INDIRECT, 1'b0, 8'h00, 1'b1, 8'h11);
    // Branch with a high target: flushed slot must not write, small core wraps.
    jump(1'b1, 1'b0, 13'h1805);
    op(7'h20, 1'b1, 8'hFF, 1'b0, 8'h00);
    // The next real instruction must not repeat the write.
    exec_wr_en = 1'b0;
    `check_eq(prog_addr, 13'h1805)
    `check_eq(prog_addr_w, 13'h0005)
    `check_eq(instr_valid, 1'b0)
    step(1);
    `check_eq(instr_word, word_of(13'h1805))
    `check_eq(instr_valid, 1'b1)
    op(7'h20, 1'b0, 8'h00, 1'b1, 8'h11);
    // Interrupt redirects both cores to the vector.
    jump(1'b0, 1'b1, 13'h0000);
    `check_eq(irq_ack, 1'b1)
    step(1);
    `check_eq(irq_ack, 1'b0)
    `check_eq(prog_addr, IRQ_VECTOR)
    `check_eq(prog_addr_w, IRQ_VECTOR)
    step(4);
    `check_eq(instr_word, word_of(IRQ_VECTOR))
    // Computed jump by writing the low counter byte; unused latch bits are dropped.
    op(OFF_PC_HIGH, 1'b1, 8'hE3, 1'b0, 8'h00);
    op(OFF_PC_LOW, 1'b1, 8'h10, 1'b0, 8'h00);
    step(1);
    `check_eq(prog_addr, 13'h0310)
    `check_eq(prog_addr_w, 13'h0310)
    `check_eq(instr_valid, 1'b0)
    conclude();
  end

endmodule
